// >>> verilog/essq_pkg.sv
// package of the event step sequencer: table layout, link codes, register map, types
// assumes a 100 MHz system clock and a 16-bit register port
package essq_pkg;
   localparam int ESSQ_STEPS = 256;
   localparam int ESSQ_WPS = 8;
   localparam int ESSQ_WORDS = ESSQ_STEPS * ESSQ_WPS;
   // link word fields and enhanced condition byte fields
   localparam int ESSQ_NEXT_LSB = 8;
   localparam int ESSQ_ENH_BIT = 7;
   localparam int ESSQ_AXRES_BIT = 6;
   localparam int ESSQ_AXSEL_BIT = 5;
   localparam int ESSQ_DIR_BIT = 4;
   localparam logic [7:0] ESSQ_LT_END = 8'h00;
   localparam logic [7:0] ESSQ_LT_BSET = 8'h42;
   localparam logic [7:0] ESSQ_LT_BCLR = 8'h62;
   localparam logic [7:0] ESSQ_LT_DELAY = 8'h44;
   localparam logic [7:0] ESSQ_LT_TPOS = 8'h4c;
   localparam logic [7:0] ESSQ_LT_APOS = 8'h6c;
   localparam logic [7:0] ESSQ_LT_TCMD = 8'h4e;
   localparam logic [7:0] ESSQ_LT_ACMD = 8'h6e;
   localparam logic [7:0] ESSQ_LT_TSTART = 8'h52;
   localparam logic [7:0] ESSQ_LT_ASTART = 8'h72;
   localparam logic [7:0] ESSQ_LT_TSPD = 8'h53;
   localparam logic [7:0] ESSQ_LT_ASPD = 8'h73;
   localparam logic [2:0] ESSQ_PAR_TPOS = 3'h0;
   localparam logic [2:0] ESSQ_PAR_APOS = 3'h1;
   localparam logic [2:0] ESSQ_PAR_TSPD = 3'h4;
   localparam logic [2:0] ESSQ_PAR_ASPD = 3'h5;
   localparam logic [2:0] ESSQ_PAR_STAT = 3'h6;
   // host command codes
   localparam logic [15:0] ESSQ_CMD_START = 16'h0045;
   localparam logic [15:0] ESSQ_CMD_HALT = 16'h0048;
   localparam logic [15:0] ESSQ_CMD_QUIT = 16'h0051;
   localparam logic [15:0] ESSQ_CMD_KILL = 16'h004b;
   // register map, word addressed
   localparam logic [11:0] ESSQ_A_CTRL = 12'h800;
   localparam logic [11:0] ESSQ_A_STRIDE = 12'h010;
   localparam logic [11:0] ESSQ_O_CVAL = 12'h000;
   localparam logic [11:0] ESSQ_O_CCODE = 12'h001;
   localparam logic [11:0] ESSQ_O_STAT = 12'h002;
   localparam logic [11:0] ESSQ_A_USED = 12'h820;
   localparam logic [15:0] ESSQ_RST_WORD = 16'h0000;
   // control loop tick
   localparam int ESSQ_CLK_NS = 10;
   localparam int ESSQ_TICK_NS = 1000000;
   localparam int ESSQ_TICK_CYC = ESSQ_TICK_NS / ESSQ_CLK_NS;

   typedef struct packed {
      logic [15:0] tpos, apos, tspd, aspd, status, cpos;
   } essq_axis_t;
   typedef struct packed {
      logic [15:0] mode, accel, decel, speed, cval, ccode;
   } essq_cmd_t;
   typedef struct packed {
      essq_cmd_t cmd;
      logic [15:0] link, lval;
   } essq_step_t;
   typedef enum logic [2:0] {
      ESSQ_IDLE = 3'b000, ESSQ_LOAD = 3'b001, ESSQ_ISSUE = 3'b010,
      ESSQ_CHECK = 3'b011, ESSQ_WAIT = 3'b100, ESSQ_PEND = 3'b101
   } essq_seq_t;
   typedef struct packed {
      essq_seq_t seq;
      logic [7:0] idx;
      essq_step_t step;
      logic [15:0] timer, stpos, sapos, refv, cval, ccode;
      logic estop;
   } essq_ctx_t;

   function automatic logic [11:0] essq_reg(input logic ax, input logic [11:0] off);
      essq_reg = ESSQ_A_CTRL + (ax ? ESSQ_A_STRIDE : 12'h000) + off;
   endfunction
endpackage

// >>> verilog/essq_table.sv
// shared step table: 2048 words of flip-flops, one bus port, one step port per axis
// assumes writes come from the register port on the same clock
`timescale 1ns/1ps
module essq_table import essq_pkg::*; #(
   parameter int WORDS = ESSQ_WORDS
) (
   input wire logic mclk_in, // system clock
   input wire logic reset_in, // async reset, high
   input wire logic wr_in, // word write strobe
   input wire logic [10:0] addr_in, // word index
   input wire logic [15:0] wdata_in, // write data
   output logic [15:0] rdata_out, // word at addr_in
   input wire logic [1:0][7:0] idx_in, // step index per axis
   output essq_step_t [1:0] step_out, // whole step per axis
   output logic [11:0] used_out // words in use
);
   typedef struct packed {
      logic [WORDS-1:0][15:0] w;
      logic [7:0] hi;
      logic any;
   } essq_tab_t;
   essq_tab_t st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (wr_in) begin
         st_nxt.w[addr_in] = wdata_in;
         // track the highest step written so the used length follows it
         if (!st_r.any || addr_in[10:3] > st_r.hi) begin
            st_nxt.hi = addr_in[10:3];
         end
         st_nxt.any = 1'b1;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_out = st_r.w[addr_in];
   assign used_out = st_r.any ? {1'b0, st_r.hi, 3'h0} + 12'h008 : 12'h000;
   for (genvar a = 0; a < 2; a++) begin : g_rd
      // eight words of a step in stored order, link word seventh
      assign step_out[a] = {st_r.w[{idx_in[a], 3'h0}], st_r.w[{idx_in[a], 3'h1}],
                            st_r.w[{idx_in[a], 3'h2}], st_r.w[{idx_in[a], 3'h3}],
                            st_r.w[{idx_in[a], 3'h4}], st_r.w[{idx_in[a], 3'h5}],
                            st_r.w[{idx_in[a], 3'h6}], st_r.w[{idx_in[a], 3'h7}]};
   end
endmodule // essq_table

// >>> verilog/essq_cond.sv
// link condition evaluator for one axis context, purely combinational
// assumes the reference value was captured by the caller at step start
`timescale 1ns/1ps
module essq_cond import essq_pkg::*; (
   input wire logic own_in, // axis owning the step
   input wire logic [7:0] ltype_in, // condition byte
   input wire logic [15:0] lval_in, // operand
   input wire essq_axis_t [1:0] axis_in, // both axes
   input wire logic [15:0] timer_in, // ms since step entry
   input wire logic [15:0] stpos_in, // target pos at step start
   input wire logic [15:0] sapos_in, // actual pos at step start
   input wire logic [15:0] ref_in, // monitored value at step start
   output logic [15:0] mon_out, // monitored value now
   output logic met_out, // condition satisfied
   output logic end_out // end of sequence
);
   essq_axis_t ax;
   logic bad;

   // reaching means crossing the operand from the side the value started on
   function automatic logic reach(input logic [15:0] v, input logic [15:0] r, input logic [15:0] op);
      reach = (r <= op) ? (v >= op) : (v <= op);
   endfunction

   always_comb begin
      ax = axis_in[own_in];
      bad = 1'b0;
      mon_out = 16'h0000;
      met_out = 1'b0;
      end_out = (ltype_in == ESSQ_LT_END);
      if (ltype_in[ESSQ_ENH_BIT]) begin
         ax = axis_in[ltype_in[ESSQ_AXSEL_BIT]];
         bad = ltype_in[ESSQ_AXRES_BIT];
         case (ltype_in[2:0])
            ESSQ_PAR_TPOS: mon_out = ax.tpos;
            ESSQ_PAR_APOS: mon_out = ax.apos;
            ESSQ_PAR_TSPD: mon_out = ax.tspd;
            ESSQ_PAR_ASPD: mon_out = ax.aspd;
            ESSQ_PAR_STAT: mon_out = ax.status;
            default: bad = 1'b1;
         endcase
         if (ltype_in[2:0] == ESSQ_PAR_STAT) begin
            met_out = ltype_in[ESSQ_DIR_BIT] ? |(ax.status & lval_in) : |(~ax.status & lval_in);
         end else begin
            met_out = ltype_in[ESSQ_DIR_BIT] ? (mon_out >= lval_in) : (mon_out <= lval_in);
         end
         met_out = met_out && !bad;
      end else begin
         case (ltype_in)
            ESSQ_LT_BSET: met_out = |(ax.status & lval_in);
            ESSQ_LT_BCLR: met_out = |(~ax.status & lval_in);
            ESSQ_LT_DELAY: begin
               mon_out = timer_in;
               met_out = timer_in >= lval_in;
            end
            ESSQ_LT_TPOS: mon_out = ax.tpos;
            ESSQ_LT_APOS: mon_out = ax.apos;
            ESSQ_LT_TCMD: mon_out = ax.tpos - ax.cpos;
            ESSQ_LT_ACMD: mon_out = ax.apos - ax.cpos;
            ESSQ_LT_TSTART: mon_out = ax.tpos - stpos_in;
            ESSQ_LT_ASTART: mon_out = ax.apos - sapos_in;
            ESSQ_LT_TSPD: mon_out = ax.tspd;
            ESSQ_LT_ASPD: mon_out = ax.aspd;
            default: bad = 1'b1;
         endcase
         if (ltype_in != ESSQ_LT_BSET && ltype_in != ESSQ_LT_BCLR && ltype_in != ESSQ_LT_DELAY) begin
            met_out = !bad && reach(mon_out, ref_in, lval_in);
         end
      end
   end
endmodule // essq_cond

// >>> verilog/essq_top.sv
// event step sequencer top: register port, shared step table, two axis sequencers
// assumes axis data and status come from control-loop logic on the same clock
`timescale 1ns/1ps
module essq_top import essq_pkg::*; #(
   parameter int TICK_CYCLES = ESSQ_TICK_CYC
) (
   input wire logic mclk_in, // system clock, 100 MHz
   input wire logic reset_in, // async reset, high
   input wire logic [11:0] reg_addr_in, // register word address
   input wire logic [15:0] reg_wdata_in, // register write data
   input wire logic reg_wr_in, // write strobe
   input wire logic reg_rd_in, // read strobe
   output logic [15:0] reg_rdata_out, // read data, cycle after strobe
   input wire essq_axis_t [1:0] axis_in, // live axis data
   output essq_cmd_t [1:0] cmd_out, // command to motion logic
   output logic [1:0] cmd_valid_out, // command pulse per axis
   output logic [1:0] running_out, // sequence active per axis
   output logic [1:0] estop_out, // emergency stop per axis
   output logic tick_out // millisecond tick pulse
);
   typedef struct packed {
      essq_ctx_t [1:0] ax;
      logic [31:0] tcnt;
      logic tick;
      logic [15:0] rdata;
      essq_cmd_t [1:0] cmd;
      logic [1:0] cvld;
   } essq_top_st_t;

   essq_top_st_t st_r, st_nxt;
   logic [15:0] tab_rdata;
   logic [11:0] tab_used;
   essq_step_t [1:0] tab_step;
   logic [1:0][7:0] tab_idx;
   logic [1:0][15:0] mon;
   logic [1:0] met;
   logic [1:0] lend;
   logic [1:0] host_cmd;

   // table reads follow each axis's current index so LOAD sees the step at once
   essq_table u_table (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .wr_in(reg_wr_in && !reg_addr_in[11]),
      .addr_in(reg_addr_in[10:0]),
      .wdata_in(reg_wdata_in),
      .rdata_out(tab_rdata),
      .idx_in(tab_idx),
      .step_out(tab_step),
      .used_out(tab_used)
   );

   for (genvar a = 0; a < 2; a++) begin : g_ax
      assign tab_idx[a] = st_r.ax[a].idx;
      assign host_cmd[a] = reg_wr_in && (reg_addr_in == essq_reg(a[0], ESSQ_O_CCODE));
      essq_cond u_cond (
         .own_in(a[0]),
         .ltype_in(st_r.ax[a].step.link[ESSQ_NEXT_LSB-1:0]),
         .lval_in(st_r.ax[a].step.lval),
         .axis_in(axis_in),
         .timer_in(st_r.ax[a].timer),
         .stpos_in(st_r.ax[a].stpos),
         .sapos_in(st_r.ax[a].sapos),
         .ref_in(st_r.ax[a].refv),
         .mon_out(mon[a]),
         .met_out(met[a]),
         .end_out(lend[a])
      );
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.cvld = 2'b00;
      st_nxt.rdata = 16'h0000;
      // free-running control loop tick; every condition retest waits for it
      st_nxt.tick = 1'b0;
      if (st_r.tcnt == 32'(TICK_CYCLES - 1)) begin
         st_nxt.tcnt = 32'h0000_0000;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.tcnt = st_r.tcnt + 32'h0000_0001;
      end

      for (int a = 0; a < 2; a++) begin
         // sequencer, one independent context per axis
         case (st_r.ax[a].seq)
            ESSQ_IDLE: begin
            end
            ESSQ_LOAD: begin
               st_nxt.ax[a].step = tab_step[a];
               st_nxt.ax[a].stpos = axis_in[a].tpos;
               st_nxt.ax[a].sapos = axis_in[a].apos;
               st_nxt.ax[a].timer = 16'h0000;
               st_nxt.ax[a].seq = ESSQ_ISSUE;
            end
            ESSQ_ISSUE: begin
               // an empty command word means the step only waits
               if (st_r.ax[a].step.cmd.ccode != 16'h0000) begin
                  st_nxt.cmd[a] = st_r.ax[a].step.cmd;
                  st_nxt.cvld[a] = 1'b1;
               end
               st_nxt.ax[a].refv = mon[a];
               st_nxt.ax[a].seq = ESSQ_CHECK;
            end
            ESSQ_CHECK: begin
               if (lend[a]) begin
                  st_nxt.ax[a].seq = ESSQ_IDLE;
               end else if (met[a]) begin
                  st_nxt.ax[a].seq = ESSQ_PEND;
               end else begin
                  st_nxt.ax[a].seq = ESSQ_WAIT;
               end
            end
            ESSQ_WAIT: begin
               if (st_r.tick && met[a]) begin
                  st_nxt.ax[a].idx = st_r.ax[a].step.link[15:ESSQ_NEXT_LSB];
                  st_nxt.ax[a].seq = ESSQ_LOAD;
               end
            end
            ESSQ_PEND: begin
               if (st_r.tick) begin
                  st_nxt.ax[a].idx = st_r.ax[a].step.link[15:ESSQ_NEXT_LSB];
                  st_nxt.ax[a].seq = ESSQ_LOAD;
               end
            end
            default: st_nxt.ax[a].seq = ESSQ_IDLE;
         endcase
         // delay timer counts ticks and holds at its top instead of wrapping
         if (st_r.tick && st_r.ax[a].seq != ESSQ_IDLE && st_r.ax[a].seq != ESSQ_LOAD &&
             st_r.ax[a].timer != 16'hffff) begin
            st_nxt.ax[a].timer = st_r.ax[a].timer + 16'h0001;
         end

         // register port writes; a host command overrides the sequencer this cycle
         if (reg_wr_in && reg_addr_in == essq_reg(a[0], ESSQ_O_CVAL)) begin
            st_nxt.ax[a].cval = reg_wdata_in;
         end
         if (host_cmd[a]) begin
            st_nxt.ax[a].ccode = reg_wdata_in;
            case (reg_wdata_in)
               ESSQ_CMD_START: begin
                  st_nxt.ax[a].idx = st_r.ax[a].cval[7:0];
                  st_nxt.ax[a].seq = ESSQ_LOAD;
                  st_nxt.ax[a].estop = 1'b0;
               end
               ESSQ_CMD_HALT: begin
                  // halt wins over an advance in the same cycle, so the index is held
                  st_nxt.ax[a].seq = ESSQ_IDLE;
                  st_nxt.ax[a].idx = st_r.ax[a].idx;
               end
               ESSQ_CMD_QUIT: begin
                  st_nxt.ax[a].seq = ESSQ_IDLE;
                  st_nxt.ax[a].idx = 8'h00;
               end
               ESSQ_CMD_KILL: begin
                  st_nxt.ax[a].seq = ESSQ_IDLE;
                  st_nxt.ax[a].idx = 8'h00;
                  st_nxt.ax[a].estop = 1'b1;
               end
               default: begin
               end
            endcase
            // every host command other than start goes on to the motion logic
            if (reg_wdata_in != ESSQ_CMD_START) begin
               st_nxt.cmd[a] = '{mode: 16'h0000, accel: 16'h0000, decel: 16'h0000,
                                 speed: 16'h0000, cval: st_r.ax[a].cval, ccode: reg_wdata_in};
               st_nxt.cvld[a] = 1'b1;
            end
         end
      end

      // register reads, data stand in the following cycle only
      if (reg_rd_in) begin
         if (!reg_addr_in[11]) begin
            st_nxt.rdata = tab_rdata;
         end else if (reg_addr_in == ESSQ_A_USED) begin
            st_nxt.rdata = {4'h0, tab_used};
         end else begin
            for (int a = 0; a < 2; a++) begin
               if (reg_addr_in == essq_reg(a[0], ESSQ_O_CVAL)) begin
                  st_nxt.rdata = st_r.ax[a].cval;
               end
               if (reg_addr_in == essq_reg(a[0], ESSQ_O_CCODE)) begin
                  st_nxt.rdata = st_r.ax[a].ccode;
               end
               if (reg_addr_in == essq_reg(a[0], ESSQ_O_STAT)) begin
                  st_nxt.rdata = {st_r.ax[a].estop, st_r.ax[a].seq != ESSQ_IDLE,
                                  3'h0, st_r.ax[a].seq, st_r.ax[a].idx};
               end
            end
         end
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata_out = st_r.rdata;
   assign cmd_out = st_r.cmd;
   assign cmd_valid_out = st_r.cvld;
   assign tick_out = st_r.tick;
   for (genvar a = 0; a < 2; a++) begin : g_out
      assign running_out[a] = st_r.ax[a].seq != ESSQ_IDLE;
      assign estop_out[a] = st_r.ax[a].estop;
   end

   // checks on the axis sequencers and on the tick pulse
   default clocking dc @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   for (genvar a = 0; a < 2; a++) begin : g_chk
      a_kill_estop: assert property (host_cmd[a] && reg_wdata_in == ESSQ_CMD_KILL |=>
            estop_out[a] && !running_out[a] && st_r.ax[a].idx == 8'h00)
         else $error("kill did not stop, zero and estop the axis");
      a_quit_zero: assert property (host_cmd[a] && reg_wdata_in == ESSQ_CMD_QUIT |=>
            !running_out[a] && st_r.ax[a].idx == 8'h00 && cmd_valid_out[a] && cmd_out[a].ccode == ESSQ_CMD_QUIT)
         else $error("quit did not stop and zero the axis");
      a_halt_keep: assert property (host_cmd[a] && reg_wdata_in == ESSQ_CMD_HALT |=>
            !running_out[a] && st_r.ax[a].idx == $past(st_r.ax[a].idx))
         else $error("halt changed the step index or kept running");
      a_start_load: assert property (host_cmd[a] && reg_wdata_in == ESSQ_CMD_START |=>
            st_r.ax[a].seq == ESSQ_LOAD && st_r.ax[a].idx == $past(st_r.ax[a].cval[7:0]) ##1
            st_r.ax[a].seq == ESSQ_ISSUE ##1 st_r.ax[a].seq == ESSQ_CHECK)
         else $error("start did not load the chosen step");
      a_end_stops: assert property (st_r.ax[a].seq == ESSQ_CHECK && lend[a] && !host_cmd[a] |=>
            !running_out[a] [*3])
         else $error("zero condition did not end the sequence");
      a_step_issue: assert property (st_r.ax[a].seq == ESSQ_LOAD && !host_cmd[a] &&
            tab_step[a].cmd.ccode != 16'h0000 |=> ##1 cmd_valid_out[a] && cmd_out[a] == $past(tab_step[a].cmd, 2))
         else $error("step command not issued after entry");
      a_pend_next: assert property (st_r.ax[a].seq == ESSQ_PEND && st_r.tick && !host_cmd[a] |=>
            st_r.ax[a].seq == ESSQ_LOAD && st_r.ax[a].idx == $past(st_r.ax[a].step.link[15:8]))
         else $error("met step did not advance to its next index");
      a_wait_tick: assert property (st_r.ax[a].seq == ESSQ_WAIT && !st_r.tick && !host_cmd[a] |=>
            st_r.ax[a].seq == ESSQ_WAIT)
         else $error("condition retested off the millisecond tick");
      a_delay_gate: assert property (st_r.ax[a].seq == ESSQ_CHECK &&
            st_r.ax[a].step.link[7:0] == ESSQ_LT_DELAY && st_r.ax[a].timer < st_r.ax[a].step.lval && !host_cmd[a] |=>
            st_r.ax[a].seq == ESSQ_WAIT)
         else $error("delay step advanced before its timer");
      a_b_any_set: assert property (st_r.ax[a].step.link[7:0] == ESSQ_LT_BSET &&
            |(axis_in[a].status & st_r.ax[a].step.lval) |-> met[a])
         else $error("status-set condition not met with a masked bit high");
      a_enh_b0: assert property (st_r.ax[a].step.link[7:0] == 8'hb0 &&
            axis_in[1].tpos >= st_r.ax[a].step.lval |-> met[a])
         else $error("enhanced byte b0 did not track axis 2 target position");
   end

   a_tick_gap: assert property (tick_out |=> !tick_out)
      else $error("tick lasted more than one cycle");
endmodule // essq_top

// >>> tb/essq_motion_model.sv
// motion logic model for both axes: follows each command the sequencer issues
// assumes commands arrive as one-cycle pulses on the sequencer clock
`timescale 1ns/1ps
module essq_motion_model import essq_pkg::*; (
   input wire logic mclk_in, // system clock
   input wire logic reset_in, // async reset, high
   input wire essq_cmd_t [1:0] cmd_in, // issued commands
   input wire logic [1:0] cmd_valid_in, // command pulses
   output essq_axis_t [1:0] axis_out // live axis data
);
   // in-position is slower than one tick on purpose, so conditions get retested
   int cnt[2];
   always_ff @(posedge mclk_in or posedge reset_in) begin
      for (int a = 0; a < 2; a++) begin
         if (reset_in) begin
            axis_out[a] <= '0;
            cnt[a] <= 0;
         end else if (cmd_valid_in[a]) begin
            axis_out[a].tpos <= cmd_in[a].cval;
            axis_out[a].cpos <= cmd_in[a].cval;
            axis_out[a].status <= 16'h0000;
            cnt[a] <= 30;
         end else if (cnt[a] > 0) begin
            cnt[a] <= cnt[a] - 1;
            if (cnt[a] == 1) begin
               axis_out[a].apos <= axis_out[a].tpos;
               axis_out[a].status <= 16'h0001;
            end
         end
      end
   end
endmodule // essq_motion_model

// >>> tb/essq_top_tb.sv
// self-checking bench of the step sequencer with a motion model on the axis side
// assumes a 20-cycle tick so that millisecond waits stay short
`timescale 1ns/1ps
module essq_top_tb import essq_pkg::*;;
   logic mclk_in = 1'b0, reset_in = 1'b1, wr = 1'b0, rd = 1'b0, tick;
   logic [11:0] addr = 12'h000;
   logic [15:0] wdata = 16'h0000, rdata, v;
   essq_axis_t [1:0] axis;
   essq_cmd_t [1:0] cmd;
   logic [1:0] cv, run, es;
   int errors = 0, cmp_count = 0;
   essq_top #(.TICK_CYCLES(20)) dut_u (.mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .axis_in(axis),
      .cmd_out(cmd), .cmd_valid_out(cv), .running_out(run), .estop_out(es), .tick_out(tick));
   essq_motion_model mm_u (.mclk_in(mclk_in), .reset_in(reset_in), .cmd_in(cmd), .cmd_valid_in(cv),
      .axis_out(axis));
   initial forever #5 mclk_in = ~mclk_in;
   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [95:0] got, input logic [95:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr_w(input logic [11:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask
   task rd_w(input logic [11:0] a, output logic [15:0] d);
      @(posedge mclk_in);
      rd <= 1'b1; addr <= a;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task put_step(input logic [7:0] s, input essq_step_t st);
      for (int w = 0; w < 8; w++) wr_w({1'b0, s, w[2:0]}, st[127-16*w -: 16]);
   endtask
   // waits for a command pulse (want_cv) or for the axis to go idle
   task wait_sig(input int ax, input bit want_cv, input int n);
      repeat (n) begin
         #1;
         if (want_cv ? cv[ax] === 1'b1 : run[ax] === 1'b0) return;
         @(posedge mclk_in);
      end
      errors++;
      $display("[ERR] t=%0t timeout got=%h exp=%h", $time, want_cv ? cv : run, want_cv ? 2'h3 : 2'h0);
      print_verdict;
   endtask
   task t_table;
      put_step(8'h04, {16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0047, 16'h0544, 16'h0003});
      put_step(8'h05, {16'h0001, 80'h0, 16'h0000, 16'h0000});
      put_step(8'h06, {16'h0001, 48'h0, 16'h0100, 16'h0047, 16'h0542, 16'h0001});
      put_step(8'h07, {16'h0001, 48'h0, 16'h0200, 16'h0047, 16'h05b0, 16'h0180});
      rd_w(12'h026, v); chk(v, 16'h0544);
      rd_w(12'h021, v); chk(v, 16'h0002);
      rd_w(12'h820, v); chk(v, 16'h0040);
      rd_w(12'h8ff, v); chk(v, 16'h0000);
      wr_w(12'h7ff, 16'h1234);
      rd_w(12'h7ff, v); chk(v, 16'h1234);
      rd_w(12'h820, v); chk(v, 16'h0800);
      $display("test table done");
   endtask
   // two tick pulses must lie exactly one tick period apart
   task t_tick;
      int n;
      n = 0;
      while (tick !== 1'b1 && n < 40) begin
         @(posedge mclk_in);
         #1 n = n + 1;
      end
      n = 0;
      do begin
         @(posedge mclk_in);
         #1 n = n + 1;
      end while (tick !== 1'b1 && n < 40);
      chk(n, 20);
      if (n >= 40) print_verdict;
      $display("test tick done");
   endtask
   task t_delay;
      wr_w(12'h800, 16'h0004);
      wr_w(12'h801, 16'h0045);
      wait_sig(0, 1'b1, 20);
      chk(cmd[0], {16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0047});
      // a three millisecond delay cannot have run out two ticks later
      repeat (40) @(posedge mclk_in);
      #1 chk(run[0], 1'b1);
      wait_sig(0, 1'b0, 100);
      rd_w(12'h802, v);
      chk({v[15:14], v[7:0]}, 10'h005);
      $display("test delay done");
   endtask
   task t_status;
      wr_w(12'h810, 16'h0006);
      wr_w(12'h811, 16'h0045);
      wait_sig(1, 1'b1, 20);
      chk(cmd[1], {16'h0001, 48'h0, 16'h0100, 16'h0047});
      // the model keeps the masked bit low for 30 cycles, so the step must still wait
      repeat (25) @(posedge mclk_in);
      #1 chk(run[1], 1'b1);
      wait_sig(1, 1'b0, 200);
      chk(axis[1].status[0], 1'b1);
      chk(run, 2'b00);
      $display("test status done");
   endtask
   task t_halt;
      wr_w(12'h800, 16'h0004);
      wr_w(12'h801, 16'h0045);
      wait_sig(0, 1'b1, 20);
      wr_w(12'h801, 16'h0048);
      rd_w(12'h802, v); chk({v[14], v[7:0]}, 9'h004);
      wr_w(12'h801, 16'h0051);
      rd_w(12'h802, v); chk({v[14], v[7:0]}, 9'h000);
      $display("test halt done");
   endtask
   task t_kill;
      wr_w(12'h800, 16'h0007);
      wr_w(12'h801, 16'h0045);
      wait_sig(0, 1'b1, 20);
      repeat (60) @(posedge mclk_in);
      #1 chk(run[0], 1'b1);
      wr_w(12'h801, 16'h004b);
      wait_sig(0, 1'b1, 5);
      chk(cmd[0], {64'h0, 16'h0007, 16'h004b});
      chk({es[0], run[0]}, 2'b10);
      rd_w(12'h802, v); chk(v[7:0], 8'h00);
      // move axis 2 past the operand; a restart then advances and clears the stop
      wr_w(12'h810, 16'h0200);
      wr_w(12'h811, 16'h0047);
      wr_w(12'h801, 16'h0045);
      wait_sig(0, 1'b0, 100);
      chk({es[0], run[0]}, 2'b00);
      $display("test kill done");
   endtask
   initial begin
      repeat (10) @(posedge mclk_in);
      reset_in <= 1'b0;
      t_table;
      t_tick;
      t_delay;
      t_status;
      t_halt;
      t_kill;
      print_verdict;
   end
endmodule // essq_top_tb
